// ---- rtl/shs_homing_sequencer.sv ----
// Homing sequencer top: registers, method sequencing and alarm
`timescale 1ns/1ps
module shs_homing_sequencer #(
  parameter int MS_DIV      = shs_pkg::MS_CYCLES,
  parameter bit HAS_REFLECT = 1'b1
) (
  input  wire logic                        CLK,
  input  wire logic                        RSTN,
  input  wire logic [shs_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [shs_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [shs_pkg::DATA_W-1:0]  RDATA,
  input  wire logic                        SERVO_ON,
  input  wire logic                        PROX_DOG,
  input  wire logic                        STROKE_FWD,
  input  wire logic                        STROKE_REV,
  input  wire logic                        INDEX_PULSE,
  input  wire logic                        AT_CREEP,
  input  wire logic                        TORQUE_AT_LIMIT,
  input  wire logic                        POS_STEP,
  output logic                             MOVE_EN,
  output logic                             MOVE_FWD,
  output logic                             CREEP_SEL,
  output logic      [shs_pkg::TL_W-1:0]    TORQUE_LIMIT,
  output logic                             TORQUE_LIMIT_REACHED,
  output logic                             HOME_SET,
  output logic                             HOMING_INCOMPLETE_ALARM,
  output logic                             IRQ
);
  import shs_pkg::*;

  if (MS_DIV < 1) begin : g_bad_div
    $error("shs_homing_sequencer: MS_DIV must be at least one");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]        ctrl_q;
  logic [7:0]        method_q;
  logic [1:0]        cfg_q;
  logic [DATA_W-1:0] after_dst_q;
  logic [15:0]       stop_time_q;
  logic [TL_W-1:0]   stop_tl_q;
  logic [TL_W-1:0]   pos_tl_q;
  logic [TL_W-1:0]   neg_tl_q;
  logic [EVT_W-1:0]  evt_q;
  logic [EVT_W-1:0]  mask_q;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;

  // Sequencer state
  shs_state_t        state_q;
  logic              fwd_q;
  logic              attained_q;
  logic              target_q;
  logic              tlc_latch_q;
  logic [DATA_W-1:0] cnt_q;
  logic              ev_done_q;
  logic              ev_alarm_q;
  logic              ev_refused_q;
  logic              start_prev_q;
  logic              frst_prev_q;
  logic              prox_prev_q;
  logic              idx_prev_q;

  logic wr_sel;
  logic rd_sel;
  logic cw_start;
  logic start_rise;
  logic frst_rise;
  logic prox_rise;
  logic idx_rise;
  logic base_fwd;
  logic invert;
  logic stroke_hit;
  logic motion_ok;
  logic dog_method;
  logic ms_tick;
  logic dwell_done;

  assign wr_sel = WR;
  assign rd_sel = RD;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q      <= 8'h00;
      method_q    <= METHOD_RST;
      cfg_q       <= 2'h0;
      after_dst_q <= AFTER_RST;
      stop_time_q <= STOP_T_RST;
      stop_tl_q   <= TL_RST;
      pos_tl_q    <= TL_RST;
      neg_tl_q    <= TL_RST;
      mask_q      <= '0;
    end else if (wr_sel) begin
      case (ADDR)
        OFS_CTRL:      ctrl_q      <= WDATA[7:0];
        OFS_METHOD:    method_q    <= WDATA[7:0];
        OFS_CONFIG:    cfg_q       <= WDATA[1:0];
        OFS_AFTER_DST: after_dst_q <= WDATA;
        OFS_STOP_TIME: stop_time_q <= WDATA[15:0];
        OFS_STOP_TL:   stop_tl_q   <= WDATA[TL_W-1:0];
        OFS_POS_TL:    pos_tl_q    <= WDATA[TL_W-1:0];
        OFS_NEG_TL:    neg_tl_q    <= WDATA[TL_W-1:0];
        OFS_EVT_MASK:  mask_q      <= WDATA[EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= '0;
    end else if (rd_sel) begin
      RDATA <= '0;
      case (ADDR)
        OFS_CTRL:      RDATA[7:0]        <= ctrl_q;
        OFS_METHOD:    RDATA[7:0]        <= method_q;
        OFS_CONFIG:    RDATA[1:0]        <= cfg_q;
        OFS_AFTER_DST: RDATA             <= after_dst_q;
        OFS_STOP_TIME: RDATA[15:0]       <= stop_time_q;
        OFS_STOP_TL:   RDATA[TL_W-1:0]   <= stop_tl_q;
        OFS_POS_TL:    RDATA[TL_W-1:0]   <= pos_tl_q;
        OFS_NEG_TL:    RDATA[TL_W-1:0]   <= neg_tl_q;
        OFS_STATUS: begin
          RDATA[SW_TARGET_BIT]   <= target_q;
          RDATA[SW_ATTAINED_BIT] <= attained_q;
          RDATA[SW_ERROR_BIT]    <= HOMING_INCOMPLETE_ALARM;
        end
        OFS_EVT:       RDATA[EVT_W-1:0]  <= evt_q;
        OFS_EVT_MASK:  RDATA[EVT_W-1:0]  <= mask_q;
        OFS_ALARM:     RDATA[11:0]       <= HOMING_INCOMPLETE_ALARM ?
                                            ALARM_CODE : 12'h000;
        default: ;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // Events and interrupt; a new event beats a clearing read
  // ----------------------------------------------------------------------
  assign evt_set = {ev_refused_q, ev_alarm_q, ev_done_q};
  assign evt_clr = (rd_sel && ADDR == OFS_EVT) ? evt_q : '0;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      evt_q <= '0;
      IRQ   <= 1'b0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      IRQ   <= |(((evt_q & ~evt_clr) | evt_set) & mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Edges and direction
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      start_prev_q <= 1'b0;
      frst_prev_q  <= 1'b0;
      prox_prev_q  <= 1'b0;
      idx_prev_q   <= 1'b0;
    end else begin
      start_prev_q <= cw_start;
      frst_prev_q  <= ctrl_q[CW_FAULT_RST];
      prox_prev_q  <= PROX_DOG;
      idx_prev_q   <= INDEX_PULSE;
    end
  end

  assign cw_start   = ctrl_q[CW_START_BIT];
  assign start_rise = cw_start && !start_prev_q; // R18
  assign frst_rise  = ctrl_q[CW_FAULT_RST] && !frst_prev_q;
  assign prox_rise  = PROX_DOG && !prox_prev_q; // R9
  assign idx_rise   = INDEX_PULSE && !idx_prev_q;

  // Forward members of each method pair; partners run reversed
  assign base_fwd = (method_q == M_IDX_FWD) || // R1
                    (method_q == M_DOG_FWD) || // R8
                    (method_q == M_CNT_FWD) ||
                    (method_q == M_STOP_FWD); // R13
  // Without the reflect option the travel setting always applies
  assign invert = cfg_q[CFG_DIR_BIT] && // R6
                  (cfg_q[CFG_REFLECT_BIT] || !HAS_REFLECT); // R7
  assign dog_method = (method_q == M_DOG_FWD) || (method_q == M_DOG_REV);
  assign motion_ok  = SERVO_ON && !HOMING_INCOMPLETE_ALARM;
  assign stroke_hit = MOVE_EN && ((MOVE_FWD && STROKE_FWD) ||
                                  (!MOVE_FWD && STROKE_REV));

  shs_tick #(
    .DIV (MS_DIV)
  ) u_tick (
    .clk  (CLK),
    .rstn (RSTN),
    .tick (ms_tick)
  );

  shs_dwell #(
    .W (16)
  ) u_dwell (
    .clk   (CLK),
    .rstn  (RSTN),
    .tick  (ms_tick),
    .hold  (state_q == ST_PUSH && TORQUE_AT_LIMIT),
    .limit (stop_time_q),
    .done  (dwell_done) // R16
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q                 <= ST_IDLE;
      fwd_q                   <= 1'b0;
      MOVE_EN                 <= 1'b0;
      CREEP_SEL               <= 1'b0;
      HOME_SET                <= 1'b0;
      HOMING_INCOMPLETE_ALARM <= 1'b0;
      attained_q              <= 1'b0;
      target_q                <= 1'b0;
      tlc_latch_q             <= 1'b0;
      cnt_q                   <= '0;
      ev_done_q               <= 1'b0;
      ev_alarm_q              <= 1'b0;
      ev_refused_q            <= 1'b0;
    end else begin
      HOME_SET     <= 1'b0;
      ev_done_q    <= 1'b0;
      ev_alarm_q   <= 1'b0;
      ev_refused_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_rise) begin
            fwd_q       <= base_fwd ^ invert; // R6
            attained_q  <= 1'b0;
            target_q    <= 1'b0;
            tlc_latch_q <= 1'b0;
            cnt_q       <= '0;
            if (HOMING_INCOMPLETE_ALARM) begin
              ev_refused_q <= 1'b1;
            end else begin
              case (method_q)
                M_CUR_A, M_CUR_B: begin
                  HOME_SET <= 1'b1; // R5
                  state_q  <= ST_DONE;
                end
                M_DATA_SET: begin
                  if (SERVO_ON) begin
                    HOME_SET <= 1'b1;
                    state_q  <= ST_DONE;
                  end else begin
                    ev_refused_q <= 1'b1; // R12
                  end
                end
                M_IDX_FWD, M_IDX_REV: begin
                  if (motion_ok) begin
                    MOVE_EN   <= 1'b1;
                    CREEP_SEL <= 1'b1; // R2
                    state_q   <= ST_CREEP_Z;
                  end else begin
                    ev_refused_q <= 1'b1;
                  end
                end
                M_DOG_FWD, M_DOG_REV, M_CNT_FWD, M_CNT_REV: begin
                  if (motion_ok) begin
                    MOVE_EN   <= 1'b1;
                    CREEP_SEL <= 1'b0;
                    state_q   <= ST_SEEK;
                  end else begin
                    ev_refused_q <= 1'b1;
                  end
                end
                M_STOP_FWD, M_STOP_REV: begin
                  if (motion_ok) begin
                    MOVE_EN   <= 1'b1;
                    CREEP_SEL <= 1'b0;
                    state_q   <= ST_PUSH;
                  end else begin
                    ev_refused_q <= 1'b1;
                  end
                end
                default: ev_refused_q <= 1'b1;
              endcase
            end
          end
        end
        ST_SEEK, ST_COUNT, ST_CREEP_Z, ST_PUSH: begin
          if (!cw_start) begin
            // Dropping the start bit halts homing without an alarm
            MOVE_EN <= 1'b0;
            state_q <= ST_IDLE;
          end else if (stroke_hit) begin
            MOVE_EN                 <= 1'b0; // R3
            HOMING_INCOMPLETE_ALARM <= 1'b1;
            ev_alarm_q              <= 1'b1;
            state_q                 <= ST_FAULT;
          end else if (state_q == ST_SEEK) begin
            if (prox_rise) begin
              CREEP_SEL <= 1'b1;
              state_q   <= dog_method ? ST_CREEP_Z : ST_COUNT; // R9
            end
          end else if (state_q == ST_COUNT) begin
            if (cnt_q >= after_dst_q) begin
              if (AT_CREEP) begin
                state_q <= ST_CREEP_Z; // R9
              end else begin
                MOVE_EN                 <= 1'b0; // R11
                HOMING_INCOMPLETE_ALARM <= 1'b1;
                ev_alarm_q              <= 1'b1;
                state_q                 <= ST_FAULT;
              end
            end else if (POS_STEP) begin
              cnt_q <= cnt_q + 1'b1;
            end
          end else if (state_q == ST_CREEP_Z) begin
            if (idx_rise) begin
              MOVE_EN  <= 1'b0; // R2
              HOME_SET <= 1'b1;
              state_q  <= ST_DONE;
            end
          end else if (dwell_done) begin
            MOVE_EN     <= 1'b0; // R16
            HOME_SET    <= 1'b1;
            tlc_latch_q <= 1'b1; // R17
            state_q     <= ST_DONE;
          end
        end
        ST_DONE: begin
          attained_q <= 1'b1; // R18
          target_q   <= 1'b1;
          ev_done_q  <= !attained_q;
          CREEP_SEL  <= 1'b0;
          if (!cw_start) begin
            state_q <= ST_IDLE;
          end
        end
        ST_FAULT: begin
          MOVE_EN   <= 1'b0;
          CREEP_SEL <= 1'b0;
          if (frst_rise) begin
            HOMING_INCOMPLETE_ALARM <= 1'b0;
            state_q                 <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign MOVE_FWD = fwd_q;

  // ----------------------------------------------------------------------
  // Torque limit selection and limit-reached flag
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      TORQUE_LIMIT         <= TL_RST;
      TORQUE_LIMIT_REACHED <= 1'b0;
    end else begin
      if (state_q == ST_PUSH && TORQUE_AT_LIMIT) begin
        TORQUE_LIMIT <= stop_tl_q; // R16
      end else if (method_q == M_STOP_REV) begin
        TORQUE_LIMIT <= neg_tl_q; // R15
      end else begin
        TORQUE_LIMIT <= pos_tl_q; // R15
      end
      TORQUE_LIMIT_REACHED <= TORQUE_AT_LIMIT || tlc_latch_q; // R17
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  property p_idx_dir;
    (state_q == ST_IDLE && start_rise && method_q == M_IDX_FWD &&
     motion_ok && !invert) |=> (MOVE_FWD && state_q == ST_CREEP_Z);
  endproperty
  a_idx_dir: assert property (p_idx_dir) else // R1
    $error("index method 34 did not start forward");

  property p_creep;
    (state_q == ST_CREEP_Z) |-> (CREEP_SEL && MOVE_EN);
  endproperty
  a_creep: assert property (p_creep) else // R2
    $error("index search not at creep speed");

  property p_stroke;
    (state_q == ST_CREEP_Z && cw_start && stroke_hit) |=>
      (state_q == ST_FAULT && !MOVE_EN && HOMING_INCOMPLETE_ALARM)
      ##1 evt_q[EVT_ALARM];
  endproperty
  a_stroke: assert property (p_stroke) else // R3
    $error("stroke end did not stop with alarm");

  property p_cur_pos;
    (state_q == ST_IDLE && start_rise && method_q == M_CUR_A &&
     !HOMING_INCOMPLETE_ALARM) |=> HOME_SET ##1 attained_q;
  endproperty
  a_cur_pos: assert property (p_cur_pos) else // R5
    $error("current position homing not completed");

  property p_dir_inv;
    (state_q == ST_IDLE && start_rise) |=>
      (MOVE_FWD == ($past(base_fwd) ^ $past(invert)));
  endproperty
  a_dir_inv: assert property (p_dir_inv) else // R6
    $error("homing direction ignores travel setting");

  property p_count_alarm;
    (state_q == ST_COUNT && cw_start && !stroke_hit &&
     cnt_q >= after_dst_q && !AT_CREEP) |=>
      (state_q == ST_FAULT && HOMING_INCOMPLETE_ALARM);
  endproperty
  a_count_alarm: assert property (p_count_alarm) else // R11
    $error("distance before creep did not alarm");

  property p_ds_refuse;
    (state_q == ST_IDLE && start_rise && method_q == M_DATA_SET &&
     !SERVO_ON) |=> (state_q == ST_IDLE && !HOME_SET) ##1
      evt_q[EVT_REFUSED];
  endproperty
  a_ds_refuse: assert property (p_ds_refuse) else // R12
    $error("data set homing accepted with servo off");

  property p_stop_tl;
    (state_q == ST_PUSH && TORQUE_AT_LIMIT) |=>
      (TORQUE_LIMIT == $past(stop_tl_q));
  endproperty
  a_stop_tl: assert property (p_stop_tl) else // R16
    $error("stopper torque limit not applied");

  property p_tlc_keep;
    (state_q == ST_DONE && tlc_latch_q) |=> TORQUE_LIMIT_REACHED;
  endproperty
  a_tlc_keep: assert property (p_tlc_keep) else // R17
    $error("torque reached flag dropped after homing");

  property p_status;
    (state_q != ST_DONE) ##1 (state_q == ST_DONE) |=>
      (attained_q && target_q);
  endproperty
  a_status: assert property (p_status) else // R18
    $error("status bits not set on completion");
endmodule

// ---- rtl/shs_pkg.sv ----
// Constants, register map and state encoding of the homing sequencer
//
// Functional notes
// [R1] Method 34 moves forward, 33 reverse
// [R2] Index homing: creep speed, first index pulse
// [R3] Stroke end in index homing: stop, alarm
// [R4] Controller starts half a turn away
// [R5] Methods 35, 37 complete with servo off
// [R6] Travel direction setting 1 reverses homing
// [R7] Reflect setting 1 applies travel direction
// [R8] Method -33 is method -1 reversed
// [R9] Count type: after-dog distance, then index
// [R10] Controller holds dog on at least 10 ms
// [R11] Distance covered before creep: alarm
// [R12] Data set homing refused when servo off
// [R13] Method -36 is method -4 reversed
// [R14] Controller sets low stopper homing speed
// [R15] Method -4 positive, -36 negative limit
// [R16] Stopper stop time qualifies torque reached
// [R17] Torque reached flag stays after homing
// [R18] Control bit 4 starts; status 12, 10
// [R19] Controller holds start 5 ms for stopper
package shs_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TL_W   = 16;

  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_METHOD    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONFIG    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_AFTER_DST = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STOP_TIME = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STOP_TL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_POS_TL    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_NEG_TL    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_EVT       = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_ALARM     = 8'h2C;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CW_START_BIT    = 4;
  localparam int CW_FAULT_RST    = 7;
  localparam int SW_TARGET_BIT   = 10;
  localparam int SW_ATTAINED_BIT = 12;
  localparam int SW_ERROR_BIT    = 13;
  localparam int CFG_DIR_BIT     = 0;
  localparam int CFG_REFLECT_BIT = 1;
  localparam int EVT_W           = 3;
  localparam int EVT_DONE        = 0;
  localparam int EVT_ALARM       = 1;
  localparam int EVT_REFUSED     = 2;

  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [7:0]        METHOD_RST   = 8'h22;
  localparam logic [DATA_W-1:0] AFTER_RST    = 32'h0000_0000;
  localparam logic [15:0]       STOP_T_RST   = 16'h0064;
  localparam logic [TL_W-1:0]   TL_RST       = 16'h0000;
  localparam logic [11:0]       ALARM_CODE   = 12'h090;

  // Method codes, two's complement in one byte
  localparam logic [7:0] M_IDX_REV   = 8'h21;
  localparam logic [7:0] M_IDX_FWD   = 8'h22;
  localparam logic [7:0] M_CUR_A     = 8'h23;
  localparam logic [7:0] M_CUR_B     = 8'h25;
  localparam logic [7:0] M_DOG_FWD   = 8'hFF;
  localparam logic [7:0] M_DOG_REV   = 8'hDF;
  localparam logic [7:0] M_CNT_FWD   = 8'hFE;
  localparam logic [7:0] M_CNT_REV   = 8'hDE;
  localparam logic [7:0] M_DATA_SET  = 8'hFD;
  localparam logic [7:0] M_STOP_FWD  = 8'hFC;
  localparam logic [7:0] M_STOP_REV  = 8'hDC;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE    = 7'b000_0001,
    ST_SEEK    = 7'b000_0010,
    ST_COUNT   = 7'b000_0100,
    ST_CREEP_Z = 7'b000_1000,
    ST_PUSH    = 7'b001_0000,
    ST_DONE    = 7'b010_0000,
    ST_FAULT   = 7'b100_0000
  } shs_state_t;

endpackage

// ---- rtl/shs_tick.sv ----
// Millisecond enable pulse divided from the system clock
`timescale 1ns/1ps
module shs_tick #(
  parameter int DIV = shs_pkg::MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      tick
);
  import shs_pkg::*;

  if (DIV < 1) begin : g_bad_div
    $error("shs_tick: DIV must be at least one");
  end

  logic [31:0] cnt_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_q >= 32'(DIV - 1)) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule

// ---- rtl/shs_dwell.sv ----
// Counts millisecond ticks while a condition holds without a break
`timescale 1ns/1ps
module shs_dwell #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         tick,
  input  wire logic         hold,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  import shs_pkg::*;

  if (W < 1 || W > 31) begin : g_bad_w
    $error("shs_dwell: W out of range");
  end

  logic [W-1:0] cnt_q;

  // Any drop of the condition restarts the wait
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (!hold) begin
      cnt_q <= '0;
    end else if (tick && cnt_q != {W{1'b1}}) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done = hold && (cnt_q >= limit);
endmodule

// ---- testbench/shs_motor_model.sv ----
// Motor and encoder model on the far side of the homing sequencer
`timescale 1ns/1ps
module shs_motor_model (
  input  wire logic clk,
  input  wire logic move_en,
  input  wire logic creep,
  output logic      index_pulse,
  output logic      pos_step,
  output logic      at_creep
);
  // First run starts about half a turn short of the Z phase
  logic [3:0] ang_q = 4'h7;
  // -------------------------------------------------
  // Shaft angle, sixteen counts to a turn
  // -------------------------------------------------
  always_ff @(posedge clk) begin
    ang_q <= move_en ? ang_q + 4'h1 : ang_q;
  end
  // Z phase once a turn, only while turning
  assign index_pulse = move_en && (ang_q == 4'hF);
  assign pos_step    = move_en;
  // Speed loop reaches creep one cycle after the request
  always_ff @(posedge clk) begin
    at_creep <= creep;
  end
endmodule

// ---- testbench/test_shs_homing_sequencer.sv ----
// Self-checking bench for the homing sequencer
`timescale 1ns/1ps
module test_shs_homing_sequencer;
  import shs_pkg::*;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic [DATA_W-1:0] rdata, d;
  logic              wr = 1'b0, rd = 1'b0, servo = 1'b1, sfwd = 1'b0;
  logic              tq = 1'b0, dog = 1'b0;
  logic              mv, fwd, crp, tlr, home, alarm, irq, idx, stp, atc;
  logic [TL_W-1:0]   tlim;
  int                n_mismatch = 0, n_compared = 0, cyc = 0;
  logic [7:0]        mth [4] = '{M_IDX_FWD, M_IDX_REV, M_IDX_FWD, M_IDX_FWD};
  logic [1:0]        cfg [4] = '{2'h0, 2'h0, 2'h3, 2'h1};
  logic              dir [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  shs_homing_sequencer #(.MS_DIV(4)) i_dut (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SERVO_ON(servo), .PROX_DOG(dog), .STROKE_FWD(sfwd),
    .STROKE_REV(1'b0), .INDEX_PULSE(idx), .AT_CREEP(atc),
    .TORQUE_AT_LIMIT(tq), .POS_STEP(stp), .MOVE_EN(mv), .MOVE_FWD(fwd),
    .CREEP_SEL(crp), .TORQUE_LIMIT(tlim), .TORQUE_LIMIT_REACHED(tlr),
    .HOME_SET(home), .HOMING_INCOMPLETE_ALARM(alarm), .IRQ(irq));
  shs_motor_model i_motor (.clk(clk), .move_en(mv), .creep(crp),
    .index_pulse(idx), .pos_step(stp), .at_creep(atc));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // Ends in the cycle of the first answer, while a home pulse still stands
  task automatic run(input logic [7:0] m);
    wreg(OFS_CTRL, 32'h0000_0000);
    wreg(OFS_METHOD, {24'h00_0000, m});
    wreg(OFS_CTRL, 32'h0000_0010);
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_home;
    for (int i = 0; i < 64 && home !== 1'b1; i++) @(negedge clk);
    chk(home, 1'b1);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rreg(OFS_METHOD);
    chk(d, 32'h0000_0022);
    rreg(8'hF0);
    chk(d, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      wreg(OFS_CONFIG, {30'h0, cfg[k]});
      run(mth[k]);
      chk(fwd, dir[k]);
      chk(crp, 1'b1);
      wait_home();
      chk(mv, 1'b0);
    end
    wreg(OFS_EVT_MASK, 32'h0000_0007);
    repeat (2) @(posedge clk);
    rreg(OFS_STATUS);
    chk({d[12:10], irq}, 4'b1011);
    rreg(OFS_EVT);
    chk(d[0], 1'b1);
    rreg(OFS_EVT);
    chk({d[0], irq}, 2'b00);
    $display("index homing done");
    run(M_IDX_FWD);
    @(posedge clk) sfwd <= 1'b1;
    repeat (4) @(negedge clk);
    chk({alarm, mv}, 2'b10);
    rreg(OFS_ALARM);
    chk(d, 32'h0000_0090);
    @(posedge clk) sfwd <= 1'b0;
    wreg(OFS_CTRL, 32'h0000_0080);
    $display("stroke end done");
    servo <= 1'b0;
    run(M_CUR_A);
    wait_home();
    run(M_CUR_B);
    wait_home();
    run(M_DATA_SET);
    chk({mv, home}, 2'b00);
    rreg(OFS_EVT);
    chk(d[2], 1'b1);
    wreg(OFS_POS_TL, 32'h0000_0123);
    servo <= 1'b1;
    wreg(OFS_NEG_TL, 32'h0000_0456);
    wreg(OFS_STOP_TL, 32'h0000_0077);
    wreg(OFS_STOP_TIME, 32'h0000_0002);
    run(M_STOP_FWD);
    chk({fwd, tlim}, {1'b1, 16'h0123});
    @(posedge clk) tq <= 1'b1;
    repeat (2) @(negedge clk);
    chk(tlim, 32'h0000_0077);
    wait_home();
    @(posedge clk) tq <= 1'b0;
    repeat (20) @(negedge clk);
    chk(tlr, 1'b1);
    run(M_STOP_REV);
    chk({fwd, tlim}, {1'b0, 16'h0456});
    $display("stopper homing done");
    wreg(OFS_AFTER_DST, 32'h0000_0004);
    run(M_DOG_REV);
    chk({fwd, crp}, 2'b00);
    @(posedge clk) dog <= 1'b1;
    wait_home();
    @(posedge clk) dog <= 1'b0;
    run(M_CNT_FWD);
    @(posedge clk) dog <= 1'b1;
    repeat (3) @(negedge clk);
    chk({crp, mv}, 2'b11);
    wait_home();
    repeat (40) @(posedge clk);
    dog <= 1'b0;
    wreg(OFS_AFTER_DST, 32'h0000_0000);
    run(M_CNT_REV);
    @(posedge clk) dog <= 1'b1;
    repeat (3) @(negedge clk);
    chk({alarm, mv}, 2'b10);
    $display("dog and count homing done");
    tally_and_finish();
  end
endmodule
